/* shared/ifd_regs.svh */
// Constants of the instruction decoder: encodings, addresses, timing.
// Assumes inclusion by bare name from the package and the design files.
`ifndef IFD_REGS_SVH
`define IFD_REGS_SVH

// Timing: oscillator periods per instruction cycle
`define IFD_QUARTERS 4
`define IFD_Q_PRE 2'h2
`define IFD_Q_READ 2'h1
`define IFD_Q_LATCH 2'h1
`define IFD_Q_WRITE 2'h2

// Word layout
`define IFD_WORD_W 16
`define IFD_W2_MARK 4'hF

// Group nibbles
`define IFD_NIB_CTRL 4'h0
`define IFD_NIB_LIT 4'h1
`define IFD_NIB_BRA 4'h2
`define IFD_NIB_BCC 4'h3
`define IFD_NIB_MOVFF 4'hC
`define IFD_PFX_BYTE 2'h1
`define IFD_PFX_BIT 2'h2

// Control sub-operations, bits 11:8
`define IFD_CS_NOP 4'h0
`define IFD_CS_TBLRD 4'h1
`define IFD_CS_TBLWR 4'h2
`define IFD_CS_RET 4'h3
`define IFD_CS_RETI 4'h4

// Literal sub-operations
`define IFD_LS_PTR 2'h3
`define IFD_LS_NONE 4'hB

// Long control, bits 15:8
`define IFD_HI_CALL0 8'hEC
`define IFD_HI_CALL1 8'hED
`define IFD_HI_GOTO 8'hEF

// Byte ops at or above this opcode are skip tests
`define IFD_BYTE_SKIP_MIN 4'hC

// Bit ops, bits 13:12
`define IFD_BOP_SET 2'h0
`define IFD_BOP_CLR 2'h1

// Field positions
`define IFD_F_D 9
`define IFD_F_A 8
`define IFD_F_S 0
`define IFD_F_CALL_S 8

// Access memory mapping
`define IFD_ACC_SPLIT 8'h80
`define IFD_ACC_LO_BANK 4'h0
`define IFD_ACC_HI_BANK 4'hF
`define IFD_PORT2_ADDR 12'hF81

// Table pointer modes
`define IFD_MM_NONE 2'h0
`define IFD_MM_POSTINC 2'h1
`define IFD_MM_POSTDEC 2'h2
`define IFD_MM_PREINC 2'h3

`endif

/* shared/ifd_pkg.sv */
// Types shared by the instruction decoder files.
// Assumes ifd_regs.svh is on the include path.
package ifd_pkg;
    `include "ifd_regs.svh"

    typedef enum logic [1:0]
    {
        IFD_GRP_BYTE = 2'h0,
        IFD_GRP_BIT = 2'h1,
        IFD_GRP_LIT = 2'h2,
        IFD_GRP_CTRL = 2'h3
    } ifd_group_t;

    // Gray codes along fetch -> second word -> flush
    typedef enum logic [1:0]
    {
        IFD_ST_FETCH = 2'h0,
        IFD_ST_WORD2 = 2'h1,
        IFD_ST_FLUSH = 2'h3
    } ifd_state_t;

    typedef enum logic [1:0]
    {
        IFD_TBL_NONE = 2'h0,
        IFD_TBL_POSTINC = 2'h1,
        IFD_TBL_POSTDEC = 2'h2,
        IFD_TBL_PREINC = 2'h3
    } ifd_tbl_t;
endpackage

/* shared/ifd_phase_if.sv */
// Quarter-phase carrier between the divider and the decoder.
// Assumes one clock; cyc_en is a one-clock pulse ending each cycle.
`timescale 1ns/1ps
interface ifd_phase_if;
    logic [1:0] quarter;
    logic cyc_en;
    modport src(output quarter, output cyc_en);
    modport snk(input quarter, input cyc_en);
endinterface

/* logic/ifd_qclk.sv */
// Quarter counter producing the instruction cycle enable.
// Assumes I_RESETN style reset from the decoder top.
`timescale 1ns/1ps
module ifd_qclk
    import ifd_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    ifd_phase_if.src ph
);
    logic [1:0] q_reg;
    logic en_reg;

    // Four oscillator periods make one instruction cycle
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            q_reg <= 2'h0;
            en_reg <= 1'b0;
        end
        else
        begin
            q_reg <= q_reg + 2'h1;
            en_reg <= (q_reg == `IFD_Q_PRE);
        end
    end

    assign ph.quarter = q_reg;
    assign ph.cyc_en = en_reg;
endmodule

/* logic/ifd_decode.sv */
// Instruction format decoder, cycle sequencer and read-modify-write timing.
// Assumes program memory presents the word of the current cycle on
// I_PROG_WORD and the ALU reports condition and result in the same cycle.
`timescale 1ns/1ps

// Functional notes
// - One word, except three two-word instructions
// - Classify as byte, bit, literal, control
// - Byte ops: file address, destination, access select
// - Destination zero accumulator, one file register; byte skip tests with destination zero write no accumulator
// - Bit ops: bit number, file, access select
// - Literal: value, pointer select, or none
// - Control: address, call mode, table mode, none
// - Second word top four bits all ones
// - Lone second word executes as no-op
// - One cycle; two when skip or jump
// - Two-word instructions take two cycles
// - Instruction cycle is four oscillator periods
// - Taken two-word branch takes three cycles
// - Every file instruction reads its register first
// - Port read clears port change flag
// - Port read data are sampled pin levels
// - Access bit picks access RAM or bank
// - Fast mode saves or restores shadow registers
// - Table mode: none, post-inc, post-dec, pre-inc
module ifd_decode
    import ifd_pkg::*;
#(
    parameter int WORD_W = `IFD_WORD_W
)
(
    input wire logic I_CORE_CLK,
    input wire logic I_RESETN,
    input wire logic [WORD_W-1:0] I_PROG_WORD,
    input wire logic I_COND_TRUE,
    input wire logic [3:0] I_BANK_SELECT,
    input wire logic [7:0] I_FILE_RDATA,
    input wire logic [7:0] I_PORT_PINS,
    input wire logic [7:0] I_ALU_RESULT,
    output logic O_CYC_EN,
    output logic O_ISSUE,
    output logic O_NOP,
    output logic [1:0] O_GROUP,
    output logic [3:0] O_SUBOP,
    output logic O_TWO_WORD,
    output logic [1:0] O_CYCLES,
    output logic [11:0] O_FILE_ADDR,
    output logic O_FILE_OP,
    output logic O_DEST_FILE,
    output logic [2:0] O_BIT_SEL,
    output logic [19:0] O_LITERAL,
    output logic O_PTR_LOAD,
    output logic [1:0] O_PTR_SEL,
    output logic O_PC_CHANGE,
    output logic O_SKIP_TEST,
    output logic O_SHADOW_SAVE,
    output logic O_SHADOW_RESTORE,
    output logic O_TBL_OP,
    output logic O_TBL_WRITE,
    output logic [1:0] O_TBL_MODE,
    output logic O_TBL_PRE_INC,
    output logic O_TBL_POST_INC,
    output logic O_TBL_POST_DEC,
    output logic O_FILE_RD,
    output logic [7:0] O_RMW_RDATA,
    output logic O_PORT_FLAG_CLR,
    output logic O_FILE_WR,
    output logic O_ACC_WR,
    output logic [7:0] O_WB_DATA
);
    ifd_phase_if ph();

    ifd_qclk u_qclk
    (
        .i_clk(I_CORE_CLK),
        .i_rst_n(I_RESETN),
        .ph(ph.src)
    );

    // Two-word first words: file move, call, goto
    function automatic logic is_two_word(input logic [15:0] w);
        is_two_word = (w[15:12] == `IFD_NIB_MOVFF) ||
            (w[15:8] == `IFD_HI_CALL0) || (w[15:8] == `IFD_HI_CALL1) ||
            (w[15:8] == `IFD_HI_GOTO);
    endfunction

    // Access RAM or banked address
    function automatic logic [11:0] resolve(input logic a,
        input logic [7:0] f, input logic [3:0] bank);
        if (a)
            resolve = {bank, f};
        else if (f < `IFD_ACC_SPLIT)
            resolve = {`IFD_ACC_LO_BANK, f};
        else
            resolve = {`IFD_ACC_HI_BANK, f};
    endfunction

    // Table pointer step from mode
    function automatic logic [2:0] tbl_steps(input logic [1:0] mm);
        case (mm)
            `IFD_MM_POSTINC: tbl_steps = 3'b010;
            `IFD_MM_POSTDEC: tbl_steps = 3'b001;
            `IFD_MM_PREINC: tbl_steps = 3'b100;
            default: tbl_steps = 3'b000;
        endcase
    endfunction

    ifd_state_t state_reg;
    ifd_state_t state_next;
    logic [15:0] first_reg;
    logic pend_cond_reg;
    logic wb_file_reg;
    logic wb_acc_reg;
    logic bit_op_reg;
    logic [1:0] bit_kind_reg;

    // Decode of the word in hand
    logic [15:0] w;
    logic [15:0] w2;
    logic iss;
    logic nop;
    ifd_group_t grp;
    logic [3:0] sub;
    logic two;
    logic [1:0] cycles;
    logic [11:0] faddr;
    logic fop;
    logic dfile;
    logic [2:0] bsel;
    logic [19:0] lit;
    logic pld;
    logic [1:0] psel;
    logic pcc;
    logic skp;
    logic ssave;
    logic srest;
    logic tbl;
    logic tblw;
    logic [1:0] mm;
    logic bop;
    logic [1:0] bkind;

    always_comb
    begin
        w = I_PROG_WORD;
        w2 = I_PROG_WORD;
        state_next = state_reg;
        iss = 1'b1;
        nop = 1'b0;
        grp = IFD_GRP_CTRL;
        sub = 4'h0;
        two = 1'b0;
        cycles = 2'h1;
        faddr = 12'h000;
        fop = 1'b0;
        dfile = 1'b0;
        bsel = 3'h0;
        lit = 20'h00000;
        pld = 1'b0;
        psel = 2'h0;
        pcc = 1'b0;
        skp = 1'b0;
        ssave = 1'b0;
        srest = 1'b0;
        tbl = 1'b0;
        tblw = 1'b0;
        mm = `IFD_MM_NONE;
        bop = 1'b0;
        bkind = 2'h0;
        case (state_reg)
            IFD_ST_FETCH:
            begin
                if (pend_cond_reg && I_COND_TRUE)
                    nop = 1'b1;
                else if (w[15:12] == `IFD_W2_MARK)
                    nop = 1'b1;
                else if (is_two_word(w))
                begin
                    iss = 1'b0;
                    state_next = IFD_ST_WORD2;
                end
                else if (w[15:14] == `IFD_PFX_BYTE)
                begin
                    grp = IFD_GRP_BYTE;
                    sub = w[13:10];
                    faddr = resolve(w[`IFD_F_A], w[7:0],
                        I_BANK_SELECT);
                    fop = 1'b1;
                    dfile = w[`IFD_F_D];
                    skp = (w[13:10] >= `IFD_BYTE_SKIP_MIN);
                end
                else if (w[15:14] == `IFD_PFX_BIT)
                begin
                    grp = IFD_GRP_BIT;
                    sub = {2'h0, w[13:12]};
                    bsel = w[11:9];
                    faddr = resolve(w[`IFD_F_A], w[7:0],
                        I_BANK_SELECT);
                    fop = 1'b1;
                    skp = w[13];
                    dfile = !w[13];
                    bop = !w[13];
                    bkind = w[13:12];
                end
                else if (w[15:12] == `IFD_NIB_LIT)
                begin
                    grp = IFD_GRP_LIT;
                    sub = w[11:8];
                    if (w[11:10] == `IFD_LS_PTR)
                    begin
                        pld = 1'b1;
                        psel = w[9:8];
                        lit = {12'h000, w[7:0]};
                    end
                    else if (w[11:8] != `IFD_LS_NONE)
                        lit = {12'h000, w[7:0]};
                end
                else if (w[15:12] == `IFD_NIB_BRA)
                begin
                    sub = w[15:12];
                    lit = {8'h00, w[11:0]};
                    pcc = 1'b1;
                    cycles = 2'h2;
                    state_next = IFD_ST_FLUSH;
                end
                else if (w[15:12] == `IFD_NIB_BCC)
                begin
                    sub = w[11:8];
                    lit = {12'h000, w[7:0]};
                    skp = 1'b1;
                end
                else if (w[15:12] == `IFD_NIB_CTRL)
                begin
                    sub = w[11:8];
                    case (w[11:8])
                        `IFD_CS_TBLRD, `IFD_CS_TBLWR:
                        begin
                            tbl = 1'b1;
                            tblw = (w[11:8] == `IFD_CS_TBLWR);
                            mm = w[1:0];
                        end
                        `IFD_CS_RET, `IFD_CS_RETI:
                        begin
                            srest = w[`IFD_F_S];
                            pcc = 1'b1;
                            cycles = 2'h2;
                            state_next = IFD_ST_FLUSH;
                        end
                        default:
                            nop = (w[11:8] == `IFD_CS_NOP);
                    endcase
                end
                else
                    nop = 1'b1;
            end
            IFD_ST_WORD2:
            begin
                // Combine held first word with this second word
                w = first_reg;
                two = 1'b1;
                cycles = 2'h2;
                state_next = IFD_ST_FETCH;
                if (w[15:12] == `IFD_NIB_MOVFF)
                begin
                    grp = IFD_GRP_BYTE;
                    sub = w[15:12];
                    lit = {8'h00, w[11:0]};
                    faddr = w2[11:0];
                    fop = 1'b1;
                    dfile = 1'b1;
                end
                else
                begin
                    sub = w[11:8];
                    lit = {w2[11:0], w[7:0]};
                    pcc = 1'b1;
                    cycles = 2'h3;
                    ssave = (w[15:8] != `IFD_HI_GOTO)
                        && w[`IFD_F_CALL_S];
                    state_next = IFD_ST_FLUSH;
                end
            end
            IFD_ST_FLUSH:
            begin
                nop = 1'b1;
                state_next = IFD_ST_FETCH;
            end
            default:
            begin
                nop = 1'b1;
                state_next = IFD_ST_FETCH;
            end
        endcase
    end

    // Sequencer advances once per instruction cycle
    always_ff @(posedge I_CORE_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
        begin
            state_reg <= IFD_ST_FETCH;
            first_reg <= 16'h0000;
            pend_cond_reg <= 1'b0;
        end
        else if (ph.cyc_en)
        begin
            state_reg <= state_next;
            if (state_reg == IFD_ST_FETCH)
                first_reg <= I_PROG_WORD;
            pend_cond_reg <= iss && !nop && skp;
        end
    end

    // Issued instruction fields
    always_ff @(posedge I_CORE_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
        begin
            O_ISSUE <= 1'b0;
            O_NOP <= 1'b1;
            O_GROUP <= 2'h3;
            O_SUBOP <= 4'h0;
            O_TWO_WORD <= 1'b0;
            O_CYCLES <= 2'h1;
            O_FILE_ADDR <= 12'h000;
            O_FILE_OP <= 1'b0;
            O_DEST_FILE <= 1'b0;
            O_BIT_SEL <= 3'h0;
            O_LITERAL <= 20'h00000;
            O_PTR_LOAD <= 1'b0;
            O_PTR_SEL <= 2'h0;
            O_PC_CHANGE <= 1'b0;
            O_SKIP_TEST <= 1'b0;
            O_SHADOW_SAVE <= 1'b0;
            O_SHADOW_RESTORE <= 1'b0;
            O_TBL_OP <= 1'b0;
            O_TBL_WRITE <= 1'b0;
            O_TBL_MODE <= 2'h0;
            O_TBL_PRE_INC <= 1'b0;
            O_TBL_POST_INC <= 1'b0;
            O_TBL_POST_DEC <= 1'b0;
            wb_file_reg <= 1'b0;
            wb_acc_reg <= 1'b0;
            bit_op_reg <= 1'b0;
            bit_kind_reg <= 2'h0;
        end
        else if (ph.cyc_en)
        begin
            O_ISSUE <= iss;
            O_NOP <= nop;
            O_GROUP <= nop ? 2'h3 : grp;
            O_SUBOP <= nop ? 4'h0 : sub;
            O_TWO_WORD <= two && !nop;
            O_CYCLES <= cycles;
            O_FILE_ADDR <= faddr;
            O_FILE_OP <= iss && !nop && fop;
            O_DEST_FILE <= dfile;
            O_BIT_SEL <= bsel;
            O_LITERAL <= lit;
            O_PTR_LOAD <= iss && !nop && pld;
            O_PTR_SEL <= psel;
            O_PC_CHANGE <= iss && !nop && pcc;
            O_SKIP_TEST <= iss && !nop && skp;
            O_SHADOW_SAVE <= iss && !nop && ssave;
            O_SHADOW_RESTORE <= iss && !nop && srest;
            O_TBL_OP <= iss && !nop && tbl;
            O_TBL_WRITE <= tblw;
            O_TBL_MODE <= mm;
            {O_TBL_PRE_INC, O_TBL_POST_INC, O_TBL_POST_DEC} <=
                (iss && !nop && tbl) ? tbl_steps(mm) : 3'b000;
            wb_file_reg <= iss && !nop && fop && dfile;
            wb_acc_reg <= iss && !nop && fop && !dfile && !skp
                && (grp == IFD_GRP_BYTE);
            bit_op_reg <= bop;
            bit_kind_reg <= bkind;
        end
        else
        begin
            O_ISSUE <= 1'b0;
        end
    end

    // Cycle marker
    always_ff @(posedge I_CORE_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
            O_CYC_EN <= 1'b0;
        else
            O_CYC_EN <= ph.cyc_en;
    end

    // Read phase: always read the named register first
    always_ff @(posedge I_CORE_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
        begin
            O_FILE_RD <= 1'b0;
            O_RMW_RDATA <= 8'h00;
            O_PORT_FLAG_CLR <= 1'b0;
        end
        else
        begin
            O_FILE_RD <= O_FILE_OP && (ph.quarter == 2'h0);
            O_PORT_FLAG_CLR <= 1'b0;
            if (O_FILE_RD && (ph.quarter == `IFD_Q_LATCH))
            begin
                if (O_FILE_ADDR == `IFD_PORT2_ADDR)
                begin
                    O_RMW_RDATA <= I_PORT_PINS;
                    O_PORT_FLAG_CLR <= 1'b1;
                end
                else
                    O_RMW_RDATA <= I_FILE_RDATA;
            end
        end
    end

    // Write-back phase
    always_ff @(posedge I_CORE_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
        begin
            O_FILE_WR <= 1'b0;
            O_ACC_WR <= 1'b0;
            O_WB_DATA <= 8'h00;
        end
        else if (ph.quarter == `IFD_Q_WRITE)
        begin
            O_FILE_WR <= wb_file_reg;
            O_ACC_WR <= wb_acc_reg;
            if (bit_op_reg && bit_kind_reg == `IFD_BOP_SET)
                O_WB_DATA <= O_RMW_RDATA | (8'h01 << O_BIT_SEL);
            else if (bit_op_reg && bit_kind_reg == `IFD_BOP_CLR)
                O_WB_DATA <= O_RMW_RDATA & ~(8'h01 << O_BIT_SEL);
            else
                O_WB_DATA <= I_ALU_RESULT;
        end
        else
        begin
            O_FILE_WR <= 1'b0;
            O_ACC_WR <= 1'b0;
        end
    end
endmodule

/* tb/ifd_prog_mem.sv */
// Program memory model presenting one word per cycle.
// Assumes O_CYC_EN marks each cycle start and reset restarts at word 0.
`timescale 1ns/1ps
module ifd_prog_mem
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_cyc_en,
    output logic [15:0] o_word
);
    logic [15:0] mem [16];
    logic [3:0] addr_reg;

    // Next word once the current one has been taken
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            addr_reg <= 4'h0;
        else if (i_cyc_en)
            addr_reg <= addr_reg + 4'h1;
    end

    assign o_word = mem[addr_reg];
endmodule

/* tb/ifd_decode_chk.sv */
// Concurrent checks on the decoder top-level ports.
// Assumes one clock domain and the shared constants.
`timescale 1ns/1ps
`include "ifd_regs.svh"
module ifd_decode_chk
    import ifd_pkg::*;
(
    input wire logic I_CORE_CLK,
    input wire logic I_RESETN,
    input wire logic [15:0] I_PROG_WORD,
    input wire logic I_COND_TRUE,
    input wire logic [3:0] I_BANK_SELECT,
    input wire logic [7:0] I_FILE_RDATA,
    input wire logic [7:0] I_PORT_PINS,
    input wire logic O_CYC_EN,
    input wire logic O_ISSUE,
    input wire logic O_NOP,
    input wire logic [1:0] O_GROUP,
    input wire logic O_TWO_WORD,
    input wire logic [1:0] O_CYCLES,
    input wire logic [11:0] O_FILE_ADDR,
    input wire logic O_DEST_FILE,
    input wire logic O_PC_CHANGE,
    input wire logic O_SKIP_TEST,
    input wire logic O_FILE_RD,
    input wire logic [7:0] O_RMW_RDATA,
    input wire logic O_PORT_FLAG_CLR,
    input wire logic O_FILE_WR,
    input wire logic O_ACC_WR
);
    default clocking @(posedge I_CORE_CLK);
    endclocking
    default disable iff (!I_RESETN);

    chk_cycle_period: assert property (O_CYC_EN |=>
        !O_CYC_EN [*3] ##1 O_CYC_EN) else $error("cycle enable spacing");
    chk_read_first: assert property (O_FILE_WR |->
        $past(O_FILE_RD, 2)) else $error("file write without read");
    chk_byte_dest: assert property (O_ISSUE && !O_NOP &&
        !O_TWO_WORD && !O_SKIP_TEST && O_GROUP == IFD_GRP_BYTE |->
        ##3 (O_FILE_WR == O_DEST_FILE && O_ACC_WR == !O_DEST_FILE))
        else $error("result destination wrong");
    chk_port_data: assert property ($past(O_FILE_RD) &&
        O_FILE_ADDR == `IFD_PORT2_ADDR |-> O_PORT_FLAG_CLR &&
        O_RMW_RDATA == $past(I_PORT_PINS)) else $error("port read wrong");
    chk_file_data: assert property ($past(O_FILE_RD) &&
        O_FILE_ADDR != `IFD_PORT2_ADDR |-> !O_PORT_FLAG_CLR &&
        O_RMW_RDATA == $past(I_FILE_RDATA)) else $error("file read wrong");
    chk_bank_sel: assert property (O_ISSUE && !O_NOP &&
        $past(I_PROG_WORD[15:14]) inside {2'h1, 2'h2} |->
        O_FILE_ADDR == {($past(I_PROG_WORD[8]) ? $past(I_BANK_SELECT) :
        ($past(I_PROG_WORD[7]) ? `IFD_ACC_HI_BANK : `IFD_ACC_LO_BANK)),
        $past(I_PROG_WORD[7:0])}) else $error("file bank wrong");
    chk_goto_flush: assert property (O_ISSUE && O_TWO_WORD &&
        O_PC_CHANGE |-> O_CYCLES == 2'h3 ##4 (O_CYC_EN && O_NOP))
        else $error("taken long branch timing");
    chk_word2_paired: assert property (O_ISSUE && O_TWO_WORD |->
        $past(O_CYC_EN, 4) && !$past(O_ISSUE, 4) && O_CYCLES != 2'h1)
        else $error("two-word pairing wrong");
    chk_lone_word2: assert property (O_CYC_EN && !O_TWO_WORD &&
        $past(I_PROG_WORD[15:12]) == `IFD_W2_MARK |-> O_NOP)
        else $error("lone second word not a no-op");
    chk_skip_true: assert property (O_ISSUE && O_SKIP_TEST &&
        !O_NOP ##3 I_COND_TRUE |=> O_NOP) else $error("skip slot not no-op");
endmodule

bind ifd_decode ifd_decode_chk u_chk
(
    .I_CORE_CLK, .I_RESETN, .I_PROG_WORD, .I_COND_TRUE, .I_BANK_SELECT,
    .I_FILE_RDATA, .I_PORT_PINS, .O_CYC_EN, .O_ISSUE, .O_NOP, .O_GROUP,
    .O_TWO_WORD, .O_CYCLES, .O_FILE_ADDR, .O_DEST_FILE, .O_PC_CHANGE,
    .O_SKIP_TEST, .O_FILE_RD, .O_RMW_RDATA, .O_PORT_FLAG_CLR, .O_FILE_WR,
    .O_ACC_WR
);

/* tb/test_instruction_format_decode_timing.sv */
// Testbench of the decoder fed by a program memory model.
// Assumes package, design, model and checker compiled first.
`timescale 1ns/1ps
module test_instruction_format_decode_timing;
    import ifd_pkg::*;
    logic I_CORE_CLK, I_RESETN, I_COND_TRUE;
    logic [15:0] I_PROG_WORD;
    logic [3:0] I_BANK_SELECT;
    logic [7:0] I_FILE_RDATA, I_PORT_PINS, I_ALU_RESULT;
    logic O_CYC_EN, O_ISSUE, O_NOP, O_TWO_WORD, O_DEST_FILE, O_PTR_LOAD;
    logic O_PC_CHANGE, O_SKIP_TEST, O_SHADOW_SAVE, O_SHADOW_RESTORE;
    logic O_TBL_OP, O_TBL_WRITE, O_TBL_PRE_INC, O_TBL_POST_INC, O_FILE_OP;
    logic [3:0] O_SUBOP;
    logic O_TBL_POST_DEC, O_FILE_RD, O_PORT_FLAG_CLR, O_FILE_WR, O_ACC_WR;
    logic [1:0] O_GROUP, O_CYCLES, O_PTR_SEL, O_TBL_MODE;
    logic [2:0] O_BIT_SEL;
    logic [11:0] O_FILE_ADDR;
    logic [19:0] O_LITERAL;
    logic [7:0] O_RMW_RDATA, O_WB_DATA;
    int errors = 0;
    int n_checks = 0;

    ifd_decode u_dut
    (
        .I_CORE_CLK, .I_RESETN, .I_PROG_WORD, .I_COND_TRUE, .I_BANK_SELECT,
        .I_FILE_RDATA, .I_PORT_PINS, .I_ALU_RESULT, .O_CYC_EN, .O_ISSUE,
        .O_NOP, .O_GROUP, .O_SUBOP, .O_TWO_WORD, .O_CYCLES, .O_FILE_ADDR,
        .O_FILE_OP, .O_DEST_FILE, .O_BIT_SEL, .O_LITERAL, .O_PTR_LOAD,
        .O_PTR_SEL, .O_PC_CHANGE, .O_SKIP_TEST, .O_SHADOW_SAVE,
        .O_SHADOW_RESTORE, .O_TBL_OP, .O_TBL_WRITE, .O_TBL_MODE,
        .O_TBL_PRE_INC, .O_TBL_POST_INC, .O_TBL_POST_DEC, .O_FILE_RD,
        .O_RMW_RDATA, .O_PORT_FLAG_CLR, .O_FILE_WR, .O_ACC_WR, .O_WB_DATA
    );

    ifd_prog_mem u_mem
    (
        .i_clk(I_CORE_CLK), .i_rst_n(I_RESETN),
        .i_cyc_en(O_CYC_EN), .o_word(I_PROG_WORD)
    );

    initial
    begin
        I_CORE_CLK = 1'b0;
        forever #20 I_CORE_CLK = ~I_CORE_CLK;
    end

    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tick;
        @(posedge I_CORE_CLK);
        #1;
    endtask

    task automatic next_cyc;
        tick();
        for (int n = 0; n < 8 && O_CYC_EN !== 1'b1; n++)
            tick();
        chk(O_CYC_EN, 1'b1);
    endtask

    task automatic restart;
        I_RESETN = 1'b0;
        I_COND_TRUE = 1'b0;
        repeat (2) tick();
        I_RESETN = 1'b1;
    endtask

    // Steps quarters 1 to 3 of a file instruction
    task automatic rmw_walk(input logic [11:0] addr, input logic fw,
        input logic port, input logic [7:0] rd, input logic [7:0] alu,
        input logic [7:0] wb);
        I_FILE_RDATA = port ? ~rd : rd;
        I_PORT_PINS = port ? rd : ~rd;
        I_ALU_RESULT = alu;
        chk(O_FILE_ADDR, addr);
        chk(O_FILE_OP, 1'b1);
        tick();
        chk(O_FILE_RD, 1'b1);
        tick();
        chk(O_RMW_RDATA, rd);
        chk(O_PORT_FLAG_CLR, port);
        tick();
        chk(O_FILE_WR, fw);
        chk(O_ACC_WR, !fw);
        chk(O_WB_DATA, wb);
    endtask

    task automatic test_byte_rmw;
        time t0;
        u_mem.mem = '{0: 16'h4690, 1: 16'h4522, default: 16'h0000};
        I_BANK_SELECT = 4'h3;
        restart();
        next_cyc();
        t0 = $time;
        chk(O_GROUP, IFD_GRP_BYTE);
        chk(O_DEST_FILE, 1'b1);
        rmw_walk(12'hF90, 1'b1, 1'b0, 8'h5A, 8'hC3, 8'hC3);
        next_cyc();
        chk(20'(($time - t0) / 40), 20'h4);
        chk(O_DEST_FILE, 1'b0);
        rmw_walk(12'h322, 1'b0, 1'b0, 8'h77, 8'h18, 8'h18);
        $display("byte rmw test done");
    endtask

    task automatic test_port_rmw;
        u_mem.mem = '{0: 16'h9A81, 1: 16'h8081, default: 16'h0000};
        restart();
        next_cyc();
        chk(O_GROUP, IFD_GRP_BIT);
        chk(O_BIT_SEL, 3'h5);
        rmw_walk(12'hF81, 1'b1, 1'b1, 8'hA5, 8'h5A, 8'h85);
        next_cyc();
        chk(O_BIT_SEL, 3'h0);
        rmw_walk(12'hF81, 1'b1, 1'b1, 8'h40, 8'hBE, 8'h41);
        $display("port rmw test done");
    endtask

    task automatic test_two_word;
        u_mem.mem = '{0: 16'hEF34, 1: 16'hF567, 3: 16'hF0AA, 4: 16'hC123,
            5: 16'hF456, default: 16'h0000};
        restart();
        next_cyc();
        chk(O_ISSUE, 1'b0);
        next_cyc();
        chk(O_TWO_WORD, 1'b1);
        chk(O_PC_CHANGE, 1'b1);
        chk(O_CYCLES, 2'h3);
        chk(O_LITERAL, 20'h56734);
        next_cyc();
        chk(O_NOP, 1'b1);
        next_cyc();
        chk(O_NOP, 1'b1);
        chk(O_GROUP, IFD_GRP_CTRL);
        next_cyc();
        chk(O_ISSUE, 1'b0);
        next_cyc();
        chk(O_CYCLES, 2'h2);
        chk(O_LITERAL[11:0], 12'h123);
        chk(O_FILE_ADDR, 12'h456);
        $display("two word test done");
    endtask

    task automatic test_literal_ctrl;
        u_mem.mem = '{0: 16'h1E5A, 1: 16'h1B00, 2: 16'h1012, 3: 16'h0100,
            4: 16'h0101, 5: 16'h0102, 6: 16'h0103, 7: 16'h0203, 8: 16'hED12,
            9: 16'hF345, 11: 16'h0301, default: 16'h0000};
        restart();
        next_cyc();
        chk(O_PTR_LOAD, 1'b1);
        chk(O_PTR_SEL, 2'h2);
        chk(O_LITERAL[7:0], 8'h5A);
        next_cyc();
        chk(O_GROUP, IFD_GRP_LIT);
        chk(O_PTR_LOAD, 1'b0);
        next_cyc();
        chk(O_LITERAL[7:0], 8'h12);
        for (int m = 0; m < 4; m++)
        begin
            next_cyc();
            chk(O_TBL_OP, 1'b1);
            chk(O_SUBOP, 4'h1);
            chk(O_TBL_MODE, 20'(m));
            chk({O_TBL_PRE_INC, O_TBL_POST_DEC, O_TBL_POST_INC},
                {m == 3, m == 2, m == 1});
        end
        next_cyc();
        chk(O_TBL_WRITE, 1'b1);
        chk(O_TBL_PRE_INC, 1'b1);
        repeat (2) next_cyc();
        chk(O_SHADOW_SAVE, 1'b1);
        chk(O_LITERAL, 20'h34512);
        repeat (2) next_cyc();
        chk(O_SHADOW_RESTORE, 1'b1);
        chk(O_SHADOW_SAVE, 1'b0);
        $display("literal and control test done");
    endtask

    task automatic test_skip_branch;
        u_mem.mem = '{0: 16'h7010, 1: 16'h4690, 2: 16'h7010, 3: 16'h4522,
            4: 16'h2005, default: 16'h0000};
        restart();
        next_cyc();
        chk(O_SKIP_TEST, 1'b1);
        I_COND_TRUE = 1'b1;
        next_cyc();
        chk(O_NOP, 1'b1);
        I_COND_TRUE = 1'b0;
        repeat (2) next_cyc();
        chk(O_NOP, 1'b0);
        next_cyc();
        chk(O_PC_CHANGE, 1'b1);
        chk(O_CYCLES, 2'h2);
        next_cyc();
        chk(O_NOP, 1'b1);
        $display("skip and branch test done");
    endtask

    task automatic complete_run;
        $display("checks=%0d errors=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (4000) @(posedge I_CORE_CLK);
        errors++;
        complete_run();
    end

    initial
    begin
        I_RESETN = 1'b0;
        I_COND_TRUE = 1'b0;
        I_BANK_SELECT = 4'h0;
        I_FILE_RDATA = 8'h00;
        I_PORT_PINS = 8'h00;
        I_ALU_RESULT = 8'h00;
        test_byte_rmw();
        test_port_rmw();
        test_two_word();
        test_literal_ctrl();
        test_skip_branch();
        complete_run();
    end
endmodule
